// [ssc_regs.sv]
`timescale 1ns/10ps
`include "ssc_cfg.svh"
module ssc_regs import ssc_pkg::*; #(
   parameter int unsigned ACT_CYC = `SSC_ACT_CYC,
   parameter int LW = 12
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // sync pins, asynchronous
   input wire logic line_sync_in_0,
   input wire logic line_sync_in_1,
   input wire logic frame_sync_in_0,
   input wire logic frame_sync_in_1,
   input wire logic green_sync_in_0,
   input wire logic green_sync_in_1,
   input wire logic ext_holdoff_pin,
   // on-chip sync processing and blue offset feedback, same clock
   input wire logic green_frame_sync,
   input wire logic regen_line_sync,
   input wire logic filt_frame_sync,
   input wire logic digital_active,
   input wire logic [7:0] blue_offset_adjust,
   // analog controls
   output logic [7:0] sep_width,
   output logic [5:0] slicer_enter,
   output logic [5:0] slicer_exit,
   output logic [8:0] blue_offset_code,
   // selections
   output logic line_src_green,
   output logic frame_src_green,
   output logic chan_sel,
   output logic intf_digital,
   // processed syncs, active high
   output logic line_sync_out,
   output logic frame_sync_out,
   output logic holdoff_out
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   localparam ssc_top_st_t TOP_RST = '{
      blue: `SSC_R_BLUE,
      sep: `SSC_R_SEP,
      enter: `SSC_R_THR,
      exit: `SSC_R_THR,
      src: `SSC_R_SRC,
      pol: `SSC_R_POL,
      lead: `SSC_R_LINES,
      trail: `SSC_R_LINES,
      aofs_en: `SSC_R_AOFS_EN,
      proc_filt: `SSC_R_PROC_FILT,
      frame_filt: `SSC_R_FRAME_FILT,
      default: '0
   };

   ssc_top_st_t q;
   ssc_top_st_t d;
   logic [`SSC_NPIN-1:0] act;
   logic [`SSC_NPIN-1:0] dpos;
   logic [`SSC_NPIN-1:0] pins;
   logic ho_line;
   logic ho_frame;
   logic ho_int;

   function automatic logic pick(input logic ovr, input logic man,
                                 input logic auto_val);
      pick = ovr ? man : auto_val;
   endfunction

   // force-high returns raw; force-low or negative detect inverts
   function automatic logic norm(input logic raw, input logic ovr,
                                 input logic man, input logic det);
      logic hi;
      hi = ovr ? man : det;
      norm = hi ? raw : ~raw;
   endfunction

   assign pins = {ext_holdoff_pin, green_sync_in_1, green_sync_in_0,
                  frame_sync_in_1, frame_sync_in_0, line_sync_in_1,
                  line_sync_in_0};

   // ----------------------------------------
   // activity and polarity detectors
   // ----------------------------------------
   for (genvar i = 0; i < `SSC_NPIN; i++) begin : g_det
      ssc_act_det #(
         .WIN_CYC(ACT_CYC)
      ) u_det (
         .ref_clk(ref_clk),
         .rst_b(rst_b),
         .lvl(q.s2[i]),
         .active(act[i]),
         .pol_pos(dpos[i])
      );
   end

   // ----------------------------------------
   // internal hold-off generator
   // ----------------------------------------
   assign ho_line = q.proc_filt ? regen_line_sync : q.line_out;
   assign ho_frame = q.pol[`SSC_B_HOLD_FILT] ? filt_frame_sync
                                             : q.frame_out;

   ssc_holdoff #(
      .LW(LW)
   ) u_ho (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .line_lvl(ho_line),
      .frame_lvl(ho_frame),
      .lead_lines(q.lead),
      .trail_lines(q.trail),
      .holdoff(ho_int)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic a_chan;
      logic a_line;
      logic a_frame;
      logic a_intf;
      logic [7:0] rel;
      a_chan = 1'b0;
      a_line = 1'b0;
      a_frame = 1'b0;
      a_intf = 1'b0;
      rel = '0;
      d = q;
      d.s1 = pins;
      d.s2 = q.s1;

      if (reg_wr) begin
         case (reg_addr)
            `SSC_A_BLUE: d.blue = reg_wdata;
            `SSC_A_SEP: d.sep = reg_wdata;
            `SSC_A_ENTER:
               d.enter = reg_wdata[`SSC_THR_MSB:`SSC_THR_LSB];
            `SSC_A_EXIT:
               d.exit = reg_wdata[`SSC_THR_MSB:`SSC_THR_LSB];
            `SSC_A_SRC: d.src = reg_wdata;
            `SSC_A_POL: d.pol = reg_wdata;
            `SSC_A_LEAD: d.lead = reg_wdata;
            `SSC_A_TRAIL: d.trail = reg_wdata;
            `SSC_A_AOFS: d.aofs_en = reg_wdata[`SSC_B_AOFS_EN];
            `SSC_A_FILT: begin
               d.proc_filt = reg_wdata[`SSC_B_PROC_FILT];
               d.frame_filt = reg_wdata[`SSC_B_FRAME_FILT];
            end
            default: ;
         endcase
      end

      // read data stands for one cycle only
      d.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            `SSC_A_BLUE: d.rdata = q.blue;
            `SSC_A_SEP: d.rdata = q.sep;
            `SSC_A_ENTER: d.rdata = {q.enter, {`SSC_THR_LSB{1'b0}}};
            `SSC_A_EXIT: d.rdata = {q.exit, {`SSC_THR_LSB{1'b0}}};
            `SSC_A_SRC: d.rdata = q.src;
            `SSC_A_POL: d.rdata = q.pol;
            `SSC_A_LEAD: d.rdata = q.lead;
            `SSC_A_TRAIL: d.rdata = q.trail;
            `SSC_A_ACT:
               d.rdata = {act[`SSC_I_L0], act[`SSC_I_L1],
                          act[`SSC_I_F0], act[`SSC_I_F1],
                          act[`SSC_I_G0], act[`SSC_I_G1],
                          act[`SSC_I_EXT], 1'b0};
            `SSC_A_PST:
               d.rdata = {dpos[`SSC_I_L0], dpos[`SSC_I_L1],
                          dpos[`SSC_I_F0], dpos[`SSC_I_F1],
                          4'h0};
            `SSC_A_AOFS: begin
               d.rdata = '0;
               d.rdata[`SSC_B_AOFS_EN] = q.aofs_en;
            end
            `SSC_A_FILT: begin
               d.rdata = '0;
               d.rdata[`SSC_B_PROC_FILT] = q.proc_filt;
               d.rdata[`SSC_B_FRAME_FILT] = q.frame_filt;
            end
            default: d.rdata = '0;
         endcase
      end

      // channel 0 wins whenever any of its inputs toggle
      a_chan = !(act[`SSC_I_L0] | act[`SSC_I_F0] | act[`SSC_I_G0]) &&
               (act[`SSC_I_L1] | act[`SSC_I_F1] | act[`SSC_I_G1]);
      d.chan = pick(q.src[`SSC_B_CHAN_OVR], q.src[`SSC_B_CHAN_MAN],
                    a_chan);

      // dedicated pins before green-embedded sync
      a_line = q.chan ? (!act[`SSC_I_L1] && act[`SSC_I_G1])
                      : (!act[`SSC_I_L0] && act[`SSC_I_G0]);
      d.line_green = pick(q.src[`SSC_B_LINE_OVR],
                          q.src[`SSC_B_LINE_MAN], a_line);
      a_frame = q.chan ? (!act[`SSC_I_F1] && act[`SSC_I_G1])
                       : (!act[`SSC_I_F0] && act[`SSC_I_G0]);
      d.frame_green = pick(q.src[`SSC_B_FRAME_OVR],
                           q.src[`SSC_B_FRAME_MAN], a_frame);

      // analog preferred while any analog sync is alive
      a_intf = !(|act[`SSC_I_G1:`SSC_I_L0]) && digital_active;
      d.intf = pick(q.src[`SSC_B_INTF_OVR], q.src[`SSC_B_INTF_MAN],
                    a_intf);

      // green-embedded sync is taken as negative-going
      if (q.line_green) begin
         d.line_out = norm(q.chan ? q.s2[`SSC_I_G1] : q.s2[`SSC_I_G0],
                           q.pol[`SSC_B_LINE_OVR],
                           q.pol[`SSC_B_LINE_MAN], 1'b0);
      end else begin
         d.line_out = norm(q.chan ? q.s2[`SSC_I_L1] : q.s2[`SSC_I_L0],
                           q.pol[`SSC_B_LINE_OVR],
                           q.pol[`SSC_B_LINE_MAN],
                           q.chan ? dpos[`SSC_I_L1]
                                  : dpos[`SSC_I_L0]);
      end
      // separator already delivers an active-high frame pulse
      if (q.frame_green) begin
         d.frame_out = green_frame_sync;
      end else begin
         d.frame_out = norm(q.chan ? q.s2[`SSC_I_F1] : q.s2[`SSC_I_F0],
                            q.pol[`SSC_B_FRAME_OVR],
                            q.pol[`SSC_B_FRAME_MAN],
                            q.chan ? dpos[`SSC_I_F1]
                                   : dpos[`SSC_I_F0]);
      end

      if (q.pol[`SSC_B_HOLD_EXT]) begin
         d.coast = norm(q.s2[`SSC_I_EXT], q.pol[`SSC_B_HOLD_OVR],
                        q.pol[`SSC_B_HOLD_MAN],
                        dpos[`SSC_I_EXT]);
      end else begin
         d.coast = ho_int;
      end

      // offset byte is excess-128 in both modes
      rel = q.blue ^ `SSC_OFS_BIAS;
      if (q.aofs_en) begin
         d.blue_code = {blue_offset_adjust[7], blue_offset_adjust} +
                       {rel[7], rel};
      end else begin
         d.blue_code = {rel[7], rel};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= TOP_RST;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign reg_rdata = q.rdata;
   assign sep_width = q.sep;
   assign slicer_enter = q.enter;
   assign slicer_exit = q.exit;
   assign blue_offset_code = q.blue_code;
   assign line_src_green = q.line_green;
   assign frame_src_green = q.frame_green;
   assign chan_sel = q.chan;
   assign intf_digital = q.intf;
   assign line_sync_out = q.line_out;
   assign frame_sync_out = q.frame_out;
   assign holdoff_out = q.coast;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   blue_manual_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      !q.aofs_en |=> blue_offset_code ==
         9'($past(q.blue)) - 9'(`SSC_OFS_BIAS))
      else $error("manual blue offset wrong");
   blue_rel_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      q.aofs_en |=> blue_offset_code ==
         9'($signed($past(blue_offset_adjust))) +
         9'($past(q.blue)) - 9'(`SSC_OFS_BIAS))
      else $error("relative blue offset wrong");
   sep_write_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == `SSC_A_SEP) |=> sep_width == $past(reg_wdata))
      else $error("separator width not stored");
   slicer_field_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == `SSC_A_ENTER) ##1
      (reg_rd && reg_addr == `SSC_A_ENTER)
      |=> reg_rdata == ($past(reg_wdata, 2) & `SSC_THR_MASK))
      else $error("slicer field readback wrong");
   line_ovr_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      q.src[`SSC_B_LINE_OVR] |=>
         line_src_green == $past(q.src[`SSC_B_LINE_MAN]))
      else $error("manual line source ignored");
   frame_ovr_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      q.src[`SSC_B_FRAME_OVR] |=>
         frame_src_green == $past(q.src[`SSC_B_FRAME_MAN]))
      else $error("manual frame source ignored");
   chan_ovr_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      q.src[`SSC_B_CHAN_OVR] |=> chan_sel == $past(q.src[`SSC_B_CHAN_MAN]))
      else $error("manual channel ignored");
   intf_ovr_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      q.src[`SSC_B_INTF_OVR] |=>
         intf_digital == $past(q.src[`SSC_B_INTF_MAN]))
      else $error("manual interface ignored");
   line_pol_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      (q.pol[`SSC_B_LINE_OVR] && !q.line_green && !q.chan) |=>
         line_sync_out ==
         ($past(q.s2[`SSC_I_L0]) ~^ $past(q.pol[`SSC_B_LINE_MAN])))
      else $error("forced line polarity wrong");
   hold_ext_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      (q.pol[`SSC_B_HOLD_EXT] && q.pol[`SSC_B_HOLD_OVR]) |=>
         holdoff_out ==
         ($past(q.s2[`SSC_I_EXT]) ~^ $past(q.pol[`SSC_B_HOLD_MAN])))
      else $error("external hold-off not passed");
   act_read_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == `SSC_A_ACT) |=>
         reg_rdata[7] == $past(act[`SSC_I_L0]) &&
         reg_rdata[2] == $past(act[`SSC_I_G1]) && !reg_rdata[0])
      else $error("activity status mapping wrong");
   ext_read_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == `SSC_A_ACT) |=>
         reg_rdata[1] == $past(act[`SSC_I_EXT]))
      else $error("shared pin activity wrong");
   pol_read_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == `SSC_A_PST) |=>
         reg_rdata[4] == $past(dpos[`SSC_I_F1]) && reg_rdata[3:0] == '0)
      else $error("polarity status mapping wrong");
endmodule

// [ssc_cfg.svh]
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SSC_A_BLUE 8'h0D
`define SSC_A_SEP 8'h0E
`define SSC_A_ENTER 8'h0F
`define SSC_A_EXIT 8'h10
`define SSC_A_SRC 8'h11
`define SSC_A_POL 8'h12
`define SSC_A_LEAD 8'h13
`define SSC_A_TRAIL 8'h14
`define SSC_A_ACT 8'h15
`define SSC_A_PST 8'h16
`define SSC_A_AOFS 8'h1C
`define SSC_A_FILT 8'h21
// ----------------------------------------
// reset values
// ----------------------------------------
`define SSC_R_BLUE 8'h80
`define SSC_R_SEP 8'h20
`define SSC_R_THR 6'h04
`define SSC_R_SRC 8'h00
`define SSC_R_POL 8'hA9
`define SSC_R_LINES 8'h00
`define SSC_R_AOFS_EN 1'b0
`define SSC_R_PROC_FILT 1'b1
`define SSC_R_FRAME_FILT 1'b0
// ----------------------------------------
// fields
// ----------------------------------------
`define SSC_THR_MSB 7
`define SSC_THR_LSB 2
`define SSC_THR_MASK 8'hFC
`define SSC_OFS_BIAS 8'h80
`define SSC_B_LINE_MAN 7
`define SSC_B_LINE_OVR 6
`define SSC_B_FRAME_MAN 5
`define SSC_B_FRAME_OVR 4
`define SSC_B_CHAN_MAN 3
`define SSC_B_CHAN_OVR 2
`define SSC_B_INTF_MAN 1
`define SSC_B_INTF_OVR 0
`define SSC_B_HOLD_MAN 3
`define SSC_B_HOLD_OVR 2
`define SSC_B_HOLD_EXT 1
`define SSC_B_HOLD_FILT 0
`define SSC_B_AOFS_EN 7
`define SSC_B_PROC_FILT 7
`define SSC_B_FRAME_FILT 5
// ----------------------------------------
// synchronised pin indices
// ----------------------------------------
`define SSC_I_L0 0
`define SSC_I_L1 1
`define SSC_I_F0 2
`define SSC_I_F1 3
`define SSC_I_G0 4
`define SSC_I_G1 5
`define SSC_I_EXT 6
`define SSC_NPIN 7
// ----------------------------------------
// timing
// ----------------------------------------
`define SSC_CLK_HZ 10000000
`define SSC_ACT_WIN_US 25000
`define SSC_ACT_CYC (`SSC_ACT_WIN_US * (`SSC_CLK_HZ / 1000000))
`endif

// [ssc_pkg.sv]
package ssc_pkg;
   typedef enum logic [3:0] {
      SSC_HO_IDLE = 4'h1,
      SSC_HO_LEAD = 4'h2,
      SSC_HO_FRAME = 4'h4,
      SSC_HO_TRAIL = 4'h8
   } ssc_ho_state_t;

   typedef struct packed {
      logic [6:0] s1;
      logic [6:0] s2;
      logic [7:0] blue;
      logic [7:0] sep;
      logic [5:0] enter;
      logic [5:0] exit;
      logic [7:0] src;
      logic [7:0] pol;
      logic [7:0] lead;
      logic [7:0] trail;
      logic aofs_en;
      logic proc_filt;
      logic frame_filt;
      logic [7:0] rdata;
      logic line_green;
      logic frame_green;
      logic chan;
      logic intf;
      logic line_out;
      logic frame_out;
      logic coast;
      logic [8:0] blue_code;
   } ssc_top_st_t;
endpackage

// [ssc_act_det.sv]
`timescale 1ns/10ps
`include "ssc_cfg.svh"
module ssc_act_det import ssc_pkg::*; #(
   parameter int unsigned WIN_CYC = `SSC_ACT_CYC,
   parameter int CW = 18
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // synchronised level
   input wire logic lvl,
   // results
   output logic active,
   output logic pol_pos
);
   typedef struct packed {
      logic prev;
      logic seen;
      logic act;
      logic pos;
      logic [CW-1:0] tmr;
      logic signed [CW:0] bal;
   } ssc_ad_st_t;

   ssc_ad_st_t q;
   ssc_ad_st_t d;
   logic win_end;

   assign win_end = (q.tmr == CW'(WIN_CYC - 1));

   always_comb begin
      d = q;
      d.prev = lvl;
      if (lvl != q.prev) begin
         d.seen = 1'b1;
      end
      // high time minus low time; mostly low means positive pulses
      d.bal = lvl ? q.bal + 1'b1 : q.bal - 1'b1;
      if (win_end) begin
         d.tmr = '0;
         d.act = q.seen || (lvl != q.prev);
         d.seen = 1'b0;
         d.pos = q.bal[CW];
         d.bal = '0;
      end else begin
         d.tmr = q.tmr + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign active = q.act;
   assign pol_pos = q.pos;

   idle_clear_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      (win_end && !q.seen && lvl == q.prev) |=> !active)
      else $error("static input still reported active");
endmodule

// [ssc_holdoff.sv]
`timescale 1ns/10ps
`include "ssc_cfg.svh"
module ssc_holdoff import ssc_pkg::*; #(
   parameter int LW = 12
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // active-high references
   input wire logic line_lvl,
   input wire logic frame_lvl,
   // line counts
   input wire logic [7:0] lead_lines,
   input wire logic [7:0] trail_lines,
   // result
   output logic holdoff
);
   typedef struct packed {
      ssc_ho_state_t state;
      logic lp;
      logic fp;
      logic [LW-1:0] cnt;
      logic [LW-1:0] total;
      logic [7:0] tcnt;
      logic ho;
   } ssc_ho_st_t;

   ssc_ho_st_t q;
   ssc_ho_st_t d;
   logic line_e;
   logic f_rise;
   logic f_fall;

   assign line_e = line_lvl & ~q.lp;
   assign f_rise = frame_lvl & ~q.fp;
   assign f_fall = ~frame_lvl & q.fp;

   always_comb begin
      d = q;
      d.lp = line_lvl;
      d.fp = frame_lvl;
      if (line_e) begin
         d.cnt = q.cnt + 1'b1;
      end
      if (f_rise) begin
         // previous frame length predicts the next frame sync
         d.total = q.cnt;
         d.cnt = '0;
         d.state = SSC_HO_FRAME;
      end else begin
         case (q.state)
            SSC_HO_IDLE: begin
               if (line_e && lead_lines != '0 && q.total != '0 &&
                   ({1'b0, q.cnt} + 1'b1 + lead_lines >= {1'b0, q.total})) begin
                  d.state = SSC_HO_LEAD;
               end
            end
            SSC_HO_LEAD: ;
            SSC_HO_FRAME: begin
               if (f_fall) begin
                  d.tcnt = '0;
                  d.state = (trail_lines == '0) ? SSC_HO_IDLE
                                                : SSC_HO_TRAIL;
               end
            end
            SSC_HO_TRAIL: begin
               if (line_e) begin
                  d.tcnt = q.tcnt + 1'b1;
                  if ({1'b0, q.tcnt} + 1'b1 >= {1'b0, trail_lines}) begin
                     d.state = SSC_HO_IDLE;
                  end
               end
            end
            default: d.state = SSC_HO_IDLE;
         endcase
      end
      d.ho = (d.state != SSC_HO_IDLE);
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '{state: SSC_HO_IDLE, default: '0};
      end else begin
         q <= d;
      end
   end

   assign holdoff = q.ho;

   frame_cover_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      f_rise |=> q.state == SSC_HO_FRAME && holdoff)
      else $error("hold-off not raised at frame sync");
   trail_none_a:
   assert property (@(posedge ref_clk) disable iff (!rst_b)
      (q.state == SSC_HO_FRAME && f_fall && trail_lines == '0)
      |=> !holdoff)
      else $error("hold-off outlived frame sync with no trail");
endmodule

// [ssc_src_model.sv]
`timescale 1ns/10ps
module ssc_src_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // sync pins, positive pulses
   output logic line_sync,
   output logic frame_sync,
   output logic green_sync
);
   logic [4:0] cnt_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 5'h00;
      end else begin
         cnt_q <= cnt_q + 5'h01;
      end
   end

   // short high pulses on line and frame, so low time outweighs high time; green is high half the time
   assign line_sync = cnt_q[2:0] < 3'h2;
   assign frame_sync = cnt_q < 5'h04;
   assign green_sync = cnt_q[1];
endmodule

// [tb_ssc_regs.sv]
`timescale 1ns/10ps
module tb_ssc_regs;
   logic ref_clk, rst_b, reg_wr, reg_rd, lsg, fsg, chs, intf, lso, fso, hso;
   logic ln, fr, gr, dact;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, sep_width, adj, r, rdv, b;
   logic [5:0] s_en, s_ex;
   logic [8:0] code;
   logic [2:0] lh, fh;
   int errors, checked, cyc;
   logic [7:0] rv[8] = '{8'h80, 8'h20, 8'h10, 8'h10, 8'h00, 8'hA9, 8'h00,
      8'h00};
   logic [7:0] ad[4] = '{8'h0D, 8'h0E, 8'h13, 8'h14};
   logic [7:0] sv[4] = '{8'hC0, 8'h30, 8'h0C, 8'h03};
   logic [3:0] se[4] = '{4'h8, 4'h4, 4'h2, 4'h1};

   ssc_regs #(.ACT_CYC(64)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_sync_in_0(ln),
      .line_sync_in_1(1'b0), .frame_sync_in_0(fr), .frame_sync_in_1(1'b0),
      .green_sync_in_0(gr), .green_sync_in_1(1'b0), .ext_holdoff_pin(fr),
      .green_frame_sync(fr), .regen_line_sync(ln), .filt_frame_sync(fr),
      .digital_active(dact), .blue_offset_adjust(adj),
      .sep_width(sep_width), .slicer_enter(s_en), .slicer_exit(s_ex),
      .blue_offset_code(code), .line_src_green(lsg),
      .frame_src_green(fsg), .chan_sel(chs), .intf_digital(intf),
      .line_sync_out(lso), .frame_sync_out(fso), .holdoff_out(hso));
   ssc_src_model src (.ref_clk(ref_clk), .rst_b(rst_b), .line_sync(ln),
      .frame_sync(fr), .green_sync(gr));

   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic logic [8:0] ofs(input logic [7:0] t, input logic [7:0] o);
      return {t[7], t} + {1'b0, o} - 9'h080;
   endfunction
   task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
      checked++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      rdv = reg_rdata;
      @(posedge ref_clk);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // pin history, three edges deep, for the sync path latency
   always @(posedge ref_clk) begin
      lh <= {lh[1:0], ln};
      fh <= {fh[1:0], fr};
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         stop_test;
      end
   end

   initial begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      adj = 8'h00;
      dact = 1'b0;
      r = 8'h39;
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
         rd(8'h0D + 8'(i));
         chk("reset", rdv, rv[i]);
      end
      chk("code", code, 9'h000);
      rd(8'h30);
      chk("unmapped", rdv, 8'h00);
      rd(8'h21);
      chk("filters", rdv, 8'h80);
      wr(8'h21, 8'hA0);
      $display("reset test done");
      for (int i = 0; i < 12; i++) begin
         r = lfsr(r);
         b = r;
         r = lfsr(r);
         adj <= r;
         wr(ad[r[1:0]], b);
         rd(ad[r[1:0]]);
         chk("rw", rdv, b);
      end
      wr(8'h0E, b);
      wr(8'h0D, b);
      // write then read in the very next cycle, no gap
      reg_addr <= 8'h0F;
      reg_wdata <= 8'h20;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      rd(8'h0F);
      chk("enter rd", rdv, 8'h20);
      wr(8'h10, 8'h43);
      @(negedge ref_clk);
      chk("sep", sep_width, b);
      chk("manual", code, ofs(8'h00, b));
      chk("enter", s_en, 6'h08);
      chk("exit", s_ex, 6'h10);
      @(posedge ref_clk);
      wr(8'h1C, 8'h80);
      @(negedge ref_clk);
      chk("feedback", code, ofs(adj, b));
      @(posedge ref_clk);
      $display("register test done");
      for (int i = 0; i < 4; i++) begin
         wr(8'h11, sv[i]);
         @(negedge ref_clk);
         chk("sel", {lsg, fsg, chs, intf}, se[i]);
         @(posedge ref_clk);
      end
      wr(8'h11, 8'h00);
      wr(8'h15, 8'h00);
      dact <= 1'b1;
      repeat (200) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("auto", {lsg, fsg, chs, intf}, 4'h0);
      @(posedge ref_clk);
      rd(8'h15);
      chk("activity", rdv, 8'hAA);
      rd(8'h16);
      chk("polarity", rdv & 8'hF0, 8'hF0);
      $display("status test done");
      for (int p = 0; p < 2; p++) begin
         wr(8'h11, 8'h44);
         wr(8'h12, {p[0], 7'h4E});
         repeat (4) @(posedge ref_clk);
         for (int k = 0; k < 40; k++) begin
            @(negedge ref_clk);
            chk("line", lso, {lh[2] ^ ~p[0]});
            chk("frame", fso, fh[2]);
            chk("hold", hso, fh[2]);
         end
         @(posedge ref_clk);
      end
      $display("sync test done");
      // no lead or trail: internal hold-off follows frame, 2 edges late
      wr(8'h13, 8'h00);
      wr(8'h14, 8'h00);
      wr(8'h12, 8'h01);
      repeat (40) @(posedge ref_clk);
      for (int k = 0; k < 40; k++) begin
         @(negedge ref_clk);
         chk("internal", hso, fh[1]);
      end
      @(posedge ref_clk);
      $display("hold-off test done");
      stop_test;
   end
endmodule
